// [sim/ccm_pin_model.sv]
`timescale 1ns/1ps
module ccm_pin_model
(
    input  wire logic [4:0] want,
    input  wire logic [4:0] pin_out,
    input  wire logic [4:0] pin_oe,
    output logic      [4:0] pin_in
);
    // a pin the module drives follows it; elsewhere the far side sets the level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & want);
endmodule : ccm_pin_model

// [sim/ccm_top_assertions.sv]
`timescale 1ns/1ps
module ccm_top_checker
    import ccm_pkg::*;
#(
    parameter int unsigned N = NUM_MODULES
)
(
    input wire logic         pclk,
    input wire logic         presetn,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [7:0]   paddr,
    input wire logic [31:0]  pwdata,
    input wire logic [31:0]  prdata,
    input wire logic         pready,
    input wire logic         pslverr,
    input wire logic [N-1:0] module_pin_in,
    input wire logic [N-1:0] module_pin_out,
    input wire logic [N-1:0] module_pin_oe,
    input wire logic         irq
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire wm0 = acc && pwrite && paddr == ADDR_MODE0;
    wire wen = acc && pwrite && paddr == ADDR_ENABLE;
    a_irq_reset: assert property ($rose(presetn) |-> !irq)
        else $error("irq out of reset");
    a_irq_masked: assert property (wen && pwdata[5:0] == 6'h00 |=> !irq)
        else $error("irq with enables off");
    a_pwm_drive: assert property (wm0 && pwdata[6] && pwdata[1] |=> module_pin_oe[0])
        else $error("pwm pin not driven");
    a_tog_drive: assert property (wm0 && pwdata[6] && pwdata[2] |=> module_pin_oe[0])
        else $error("toggle pin not driven");
    a_comp_gate: assert property (wm0 && !pwdata[6] |=> !module_pin_oe[0])
        else $error("pin driven without comparator");
    a_pin_quiet: assert property ((module_pin_oe == '0) [*2] |-> $stable(module_pin_out))
        else $error("undriven pin moved");
    a_err_zero: assert property (acc && pslverr && !pwrite |-> prdata == '0)
        else $error("refused read gave data");
    a_mode_top: assert property (acc && !pwrite && paddr == ADDR_MODE0 |-> prdata[31:7] == '0)
        else $error("mode upper bits set");
endmodule : ccm_top_checker
bind ccm_top ccm_top_checker #(.N(N)) i_chk (.*);

// [sim/compare_capture_module_mode_bench.sv]
`timescale 1ns/1ps
module compare_capture_module_mode_bench;
    import ccm_pkg::*;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic        pready, pslverr, irq, err, oe, e;
    logic [7:0]  paddr = 8'h00, off;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [4:0]  want = 5'h00, exp_pin = 5'h00, pin_in, pin_out, pin_oe;
    logic [6:0]  m, cor [6] = '{7'h42, 7'h48, 7'h49, 7'h11, 7'h20, 7'h45};
    int          seed = 96414, fails = 0, checks = 0, cyc = 0, n;
    ccm_top i_dut (.module_pin_in(pin_in), .module_pin_out(pin_out),
                   .module_pin_oe(pin_oe), .*);
    ccm_pin_model i_pins (.want(want), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
    initial forever #10 pclk = ~pclk;
    // a hang is counted as a mismatch before the verdict
    always @(posedge pclk)
        if (++cyc > 5000 && ++fails > 0)
            close_out();
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic cmp(string s, logic [31:0] x, logic [31:0] g);
        checks++;
        if (g !== x)
            fails++;
        if (g !== x)
            $display("unexpected %s expected %h seen %h", s, x, g);
    endtask : cmp
    function automatic logic flag_exp(logic [6:0] md, logic lvl);
        return (md[6] & md[3]) | ((md[6] & (md[1] | md[2])) ? md[3'h4 + lvl] : (md[5] | md[4]));
    endfunction : flag_exp
    task automatic close_out();
        if (fails == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, 8'h7C, 32'h0);
        cmp("slverr", 32'h1, 32'(err));
        cmp("unmapped", 32'h0, rd);
        for (int i = 0; i < 14; i++)
        begin
            n = i % 5;
            off = MODULE_STRIDE * 8'(n);
            m = (i < 6) ? cor[i] : 7'($random(seed));
            apb(1'h1, ADDR_CTRL, 32'h0);
            apb(1'h1, ADDR_CNT, 32'h0);
            apb(1'h1, ADDR_CMP0 + off, 32'h20);
            // bit 7 is written as one on purpose: it must read back as zero
            apb(1'h1, ADDR_MODE0 + off, {25'h1, m});
            apb(1'h0, ADDR_MODE0 + off, 32'h0);
            cmp("mode", 32'(m), rd);
            apb(1'h1, ADDR_CTRL, 32'h1);
            apb(1'h1, ADDR_CLEAR, 32'h3F);
            oe = m[6] & (m[1] | m[2]);
            e = (m[6] & m[1]) | ~exp_pin[n];
            want[n] <= 1'h1;
            repeat (20) @(posedge pclk);
            want[n] <= 1'h0;
            repeat (40) @(negedge pclk);
            cmp("oe", 32'(oe), 32'(pin_oe[n]));
            if (oe)
                cmp("pin", 32'(e), 32'(pin_out[n]));
            apb(1'h0, ADDR_STATUS, 32'h0);
            cmp("status", 32'(flag_exp(m, e)) << n, rd);
            // pin edge lands two cycles late: counter stood at 5 on the rise, 25 on the fall
            if (!oe && (m[5] || m[4]))
            begin
                apb(1'h0, ADDR_CAPT0 + off, 32'h0);
                cmp("capture", m[4] ? 32'h19 : 32'h5, rd);
            end
            apb(1'h1, ADDR_ENABLE, 32'h1 << n);
            @(negedge pclk);
            cmp("irq", 32'(flag_exp(m, e) & m[0]), 32'(irq));
            apb(1'h1, ADDR_ENABLE, 32'h0);
            @(negedge pclk);
            cmp("irq", 32'h0, 32'(irq));
            exp_pin[n] = oe ? e : exp_pin[n];
            apb(1'h1, ADDR_MODE0 + off, 32'h0);
        end
        close_out();
    end
endmodule : compare_capture_module_mode_bench

// [verilog/ccm_channel.sv]
`timescale 1ns/1ps
module ccm_channel
    import ccm_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [6:0]        mode,
    input  wire logic [CNT_W-1:0]  count,
    input  wire logic [CNT_W-1:0]  compare,
    input  wire logic              pin_sync,
    output logic                   capture_event,
    output logic                   match_event,
    output logic                   pin_out,
    output logic                   pin_oe
);
    logic pin_prev_ff;
    logic pin_lvl_ff;
    logic nxt_pin_lvl;

    wire comp_en  = mode[BIT_COMP];
    wire rise     = pin_sync & ~pin_prev_ff;
    wire fall     = ~pin_sync & pin_prev_ff;
    wire is_equal = comp_en & (count == compare);
    wire pwm_on   = comp_en & mode[BIT_PWM];

    assign capture_event = (mode[BIT_FALL] & fall)
                         | (mode[BIT_RISE] & rise);
    // flag only in software timer mode: comparator and match both set
    assign match_event   = is_equal & mode[BIT_MATCH];
    assign pin_oe        = pwm_on | (comp_en & mode[BIT_TOGGLE]);
    // pwm: pin low while counter below compare value, high from there on
    assign nxt_pin_lvl   = pwm_on ? (count >= compare)
                         : (is_equal & mode[BIT_TOGGLE]) ? ~pin_lvl_ff
                         : pin_lvl_ff;
    assign pin_out       = pin_lvl_ff;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_prev_ff <= 1'b0;
            pin_lvl_ff  <= 1'b0;
        end
        else
        begin
            pin_prev_ff <= pin_sync;
            pin_lvl_ff  <= nxt_pin_lvl;
        end
    end
endmodule : ccm_channel

// [verilog/ccm_pkg.sv]
package ccm_pkg;
    localparam int unsigned NUM_MODULES = 5;
    localparam int unsigned CNT_W       = 16;
    // ***************************************************************
    // register map (byte addresses)
    // ***************************************************************
    localparam logic [7:0] ADDR_MODE0    = 8'h00;
    localparam logic [7:0] ADDR_CMP0     = 8'h20;
    localparam logic [7:0] ADDR_CNT      = 8'h40;
    localparam logic [7:0] ADDR_STATUS   = 8'h44;
    localparam logic [7:0] ADDR_CLEAR    = 8'h48;
    localparam logic [7:0] ADDR_ENABLE   = 8'h4C;
    localparam logic [7:0] ADDR_CTRL     = 8'h50;
    localparam logic [7:0] ADDR_CAPT0    = 8'h60;
    localparam logic [7:0] MODULE_STRIDE = 8'h04;
    // ***************************************************************
    // mode register fields
    // ***************************************************************
    localparam int unsigned BIT_COMP   = 6;
    localparam int unsigned BIT_RISE   = 5;
    localparam int unsigned BIT_FALL   = 4;
    localparam int unsigned BIT_MATCH  = 3;
    localparam int unsigned BIT_TOGGLE = 2;
    localparam int unsigned BIT_PWM    = 1;
    localparam int unsigned BIT_FLAGIE = 0;
    localparam logic [6:0]  MODE_RESET = 7'h00;
    localparam logic [6:0]  MODE_MASK  = 7'h7F;
    // status bits: 0..4 module flags, 5 counter overflow
    localparam int unsigned EV_W       = 6;
    localparam int unsigned EV_OVF     = 5;
endpackage : ccm_pkg

// [verilog/ccm_top.sv]
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module ccm_top
    import ccm_pkg::*;
#(
    parameter int unsigned N = NUM_MODULES
)
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic [N-1:0]  module_pin_in,
    output logic [N-1:0]       module_pin_out,
    output logic [N-1:0]       module_pin_oe,
    output logic               irq
);
    import ccm_pkg::*;

    // ***************************************************************
    // state
    // ***************************************************************
    logic [6:0]        mode_ff    [N];
    logic [CNT_W-1:0]  cmp_ff     [N];
    logic [CNT_W-1:0]  capt_ff    [N];
    logic [CNT_W-1:0]  count_ff;
    logic              run_ff;
    logic [N-1:0]      flag_ff;
    logic [N-1:0]      flag_ie;
    logic              ovf_ff;
    logic [EV_W-1:0]   irq_en_ff;
    logic [N-1:0]      sync1_ff;
    logic [N-1:0]      sync2_ff;
    logic [31:0]       prdata_ff;

    logic [N-1:0]      cap_ev;
    logic [N-1:0]      match_ev;
    logic [N-1:0]      mode_we;
    logic [N-1:0]      cmp_we;
    logic [N-1:0]      mode_hit;
    logic [N-1:0]      cmp_hit;
    logic [N-1:0]      capt_hit;
    logic [31:0]       mode_rd    [N];
    logic [31:0]       cmp_rd     [N];
    logic [31:0]       capt_rd    [N];

    // ***************************************************************
    // bus decode
    // ***************************************************************
    wire              acc      = psel & penable;
    wire              wr       = acc & pwrite;
    wire              rd       = acc & ~pwrite;
    wire              hit_cnt  = (paddr == ADDR_CNT);
    wire              hit_st   = (paddr == ADDR_STATUS);
    wire              hit_clr  = (paddr == ADDR_CLEAR);
    wire              hit_en   = (paddr == ADDR_ENABLE);
    wire              hit_ctl  = (paddr == ADDR_CTRL);
    wire              any_mod  = |{mode_hit, cmp_hit, capt_hit};
    wire              mapped   = any_mod | hit_cnt | hit_st | hit_clr | hit_en | hit_ctl;
    wire [EV_W-1:0]   clr_bits = (wr & hit_clr) ? pwdata[EV_W-1:0] : '0;
    wire [EV_W-1:0]   status   = {ovf_ff, flag_ff};
    wire              ovf_ev   = run_ff & (&count_ff);

    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata  = prdata_ff;
    // a module flag needs its mode enable bit as well as its enable register bit
    assign irq     = |(status & irq_en_ff & {1'b1, flag_ie});

    // ***************************************************************
    // per-module slices
    // ***************************************************************
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_mod
            assign mode_hit[g] = (paddr == 8'(ADDR_MODE0 + g * MODULE_STRIDE));
            assign cmp_hit[g]  = (paddr == 8'(ADDR_CMP0 + g * MODULE_STRIDE));
            assign capt_hit[g] = (paddr == 8'(ADDR_CAPT0 + g * MODULE_STRIDE));
            assign mode_we[g]  = wr & mode_hit[g];
            assign cmp_we[g]   = wr & cmp_hit[g];
            assign flag_ie[g]  = mode_ff[g][BIT_FLAGIE];
            assign mode_rd[g]  = mode_hit[g] ? {25'h0, mode_ff[g]} : '0;
            assign cmp_rd[g]   = cmp_hit[g] ? {16'h0, cmp_ff[g]} : '0;
            assign capt_rd[g]  = capt_hit[g] ? {16'h0, capt_ff[g]} : '0;

            ccm_channel u_chan (
                .pclk          (pclk),
                .presetn       (presetn),
                .mode          (mode_ff[g]),
                .count         (count_ff),
                .compare       (cmp_ff[g]),
                .pin_sync      (sync2_ff[g]),
                .capture_event (cap_ev[g]),
                .match_event   (match_ev[g]),
                .pin_out       (module_pin_out[g]),
                .pin_oe        (module_pin_oe[g])
            );

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    mode_ff[g] <= MODE_RESET;
                    cmp_ff[g]  <= '0;
                    capt_ff[g] <= '0;
                    flag_ff[g] <= 1'b0;
                end
                else
                begin
                    if (mode_we[g])
                        mode_ff[g] <= pwdata[6:0] & MODE_MASK;
                    if (cmp_we[g])
                        cmp_ff[g] <= pwdata[CNT_W-1:0];
                    if (cap_ev[g])
                        capt_ff[g] <= count_ff;
                    // set wins over a clear in the same cycle
                    flag_ff[g] <= match_ev[g] | cap_ev[g]
                                | (flag_ff[g] & ~clr_bits[g]);
                end
            end
        end
    endgenerate

    // ***************************************************************
    // read mux, counter, shared registers
    // ***************************************************************
    logic [31:0] nxt_prdata;
    always_comb
    begin
        nxt_prdata = 32'h0;
        for (int i = 0; i < N; i++)
            nxt_prdata = nxt_prdata | mode_rd[i] | cmp_rd[i] | capt_rd[i];
        if (hit_cnt)
            nxt_prdata = {16'h0, count_ff};
        else if (hit_st)
            nxt_prdata = {26'h0, status};
        else if (hit_en)
            nxt_prdata = {26'h0, irq_en_ff};
        else if (hit_ctl)
            nxt_prdata = {31'h0, run_ff};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_ff  <= '0;
            sync2_ff  <= '0;
            count_ff  <= '0;
            run_ff    <= 1'b0;
            ovf_ff    <= 1'b0;
            irq_en_ff <= '0;
            prdata_ff <= 32'h0;
        end
        else
        begin
            sync1_ff <= module_pin_in;
            sync2_ff <= sync1_ff;
            if (wr & hit_cnt)
                count_ff <= pwdata[CNT_W-1:0];
            else if (run_ff)
                count_ff <= count_ff + 1'b1;
            if (wr & hit_ctl)
                run_ff <= pwdata[0];
            if (wr & hit_en)
                irq_en_ff <= pwdata[EV_W-1:0];
            ovf_ff <= ovf_ev | (ovf_ff & ~clr_bits[EV_OVF]);
            if (psel & ~penable & ~pwrite)
                prdata_ff <= nxt_prdata;
        end
    end
endmodule : ccm_top
